/* File: pcm_codec_serial_port.sv */
// serial pcm port of a single-channel codec, with axi4-lite registers
// assumes highway bit clocks and 8 kHz syncs arrive on the link pins
// Function
// - receive sync picks out own word
// - static receive sync powers receive down
// - static transmit sync powers transmit down
// - seven-bit toggle edge triggers 7-bit decode
// - transmit shifts at supplied bit clock rate
// - each conversion leaves as 8-bit word
// - transmit sync aligns the output word
// - serial output is open drain, low only
// - sections run on common or separate clocks
// - loopback select low gives analog loopback
// - received words convert to analog samples
`timescale 1ns/1ps
module pcm_codec_serial_port #(
   parameter int IDLE_LIMIT = pcm_port_pkg::IDLE_CYCLES
) (
   // core clock, reset, enable
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // transmit link
   input wire logic transmit_bit_clock_i,
   input wire logic transmit_frame_sync_i,
   output logic serial_code_output_o,
   output logic serial_code_output_oe_n_o,
   // receive link
   input wire logic receive_bit_clock_i,
   input wire logic receive_frame_sync_i,
   input wire logic serial_code_input_i,
   // control pins
   input wire logic seven_bit_decode_toggle_i,
   input wire logic loopback_select_i,
   // analog-side samples
   input wire logic [7:0] adc_code_i,
   input wire logic adc_valid_i,
   output logic [7:0] dac_code_o,
   output logic dac_valid_o,
   output logic decode_7bit_o,
   output logic analog_loopback_o,
   output logic tx_powered_o,
   output logic rx_powered_o
);
   typedef struct packed {
      logic [1:0] tx_sync_ff;
      logic tx_sync_last;
      logic [1:0] rx_sync_ff;
      logic [2:0] rx_tog_ff;
      logic [1:0] bs_ff;
      logic bs_last;
      logic [1:0] lb_ff;
      logic [1:0] ctrl;
      logic [7:0] tx_word;
      logic [7:0] tx_hold;
      logic [7:0] rx_word;
      logic rx_new;
      logic dac_valid;
      logic dec7;
      logic [15:0] dec_cnt;
      logic aw_done;
      logic w_done;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } port_state_t;
   port_state_t st_reg;
   port_state_t st_next;

   logic tx_active;
   logic rx_active;
   logic tx_line;
   logic [7:0] rx_link_word;
   logic rx_link_toggle;
   logic [7:0] tx_link_word;
   logic [7:0] rd_value;
   logic [31:0] rd_word;
   logic rd_ok;

   // static syncs power sections down
   pcm_activity_detect #(.IDLE_LIMIT(IDLE_LIMIT)) tx_detect (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clk_en_i(clk_en_i),
      .sync_level_i(st_reg.tx_sync_ff[1]),
      .active_o(tx_active)
   );
   pcm_activity_detect #(.IDLE_LIMIT(IDLE_LIMIT)) rx_detect (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clk_en_i(clk_en_i),
      .sync_level_i(st_reg.rx_sync_ff[1]),
      .active_o(rx_active)
   );

   // separate sections so clocks may be common or independent
   pcm_link_section tx_section (
      .link_clk_i(transmit_bit_clock_i),
      .frame_sync_i(transmit_frame_sync_i),
      .serial_in_i(1'b1),
      .tx_word_i(tx_link_word),
      .serial_out_o(tx_line),
      .rx_word_o(),
      .rx_toggle_o()
   );
   pcm_link_section rx_section (
      .link_clk_i(receive_bit_clock_i),
      .frame_sync_i(receive_frame_sync_i),
      .serial_in_i(serial_code_input_i),
      .tx_word_i(8'hFF),
      .serial_out_o(),
      .rx_word_o(rx_link_word),
      .rx_toggle_o(rx_link_toggle)
   );

   // held copy only moves just after a sync falls, far from the next
   // sampling edge, so the link domain never catches it mid-change
   assign tx_link_word = st_reg.tx_hold;

   // read mux
   always_comb begin
      rd_value = 8'h00;
      rd_word = 32'h0;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         pcm_port_pkg::REG_CTRL: rd_word = {30'h0, st_reg.ctrl};
         pcm_port_pkg::REG_STATUS: rd_word = {28'h0, analog_loopback_o,
            st_reg.rx_new, rx_active, tx_active};
         pcm_port_pkg::REG_TX_DATA: rd_value = st_reg.tx_word;
         pcm_port_pkg::REG_RX_DATA: rd_value = st_reg.rx_word;
         pcm_port_pkg::REG_DECODE_CNT: rd_word = {16'h0, st_reg.dec_cnt};
         default: rd_ok = 1'b0;
      endcase
      if (rd_value != 8'h00) begin
         rd_word = {24'h0, rd_value};
      end
   end

   // next state: synchronisers, crossings, bus slave
   always_comb begin
      st_next = st_reg;
      st_next.tx_sync_ff = {st_reg.tx_sync_ff[0], transmit_frame_sync_i};
      st_next.rx_sync_ff = {st_reg.rx_sync_ff[0], receive_frame_sync_i};
      st_next.rx_tog_ff = {st_reg.rx_tog_ff[1:0], rx_link_toggle};
      st_next.bs_ff = {st_reg.bs_ff[0], seven_bit_decode_toggle_i};
      st_next.lb_ff = {st_reg.lb_ff[0], loopback_select_i};
      st_next.bs_last = st_reg.bs_ff[1];
      st_next.tx_sync_last = st_reg.tx_sync_ff[1];
      st_next.dac_valid = 1'b0;
      st_next.dec7 = 1'b0;
      // analog conversion result becomes the word of the first frame after the next sync fall
      if (adc_valid_i && tx_active) begin
         st_next.tx_word = adc_code_i;
      end
      // refresh the link copy once the sync has been seen to fall
      if (!st_reg.tx_sync_ff[1] && st_reg.tx_sync_last) begin
         st_next.tx_hold = st_reg.tx_word;
      end
      // received word toggle crossed, then handed to the dac
      if ((st_reg.rx_tog_ff[2] != st_reg.rx_tog_ff[1]) && rx_active) begin
         st_next.rx_word = rx_link_word;
         st_next.rx_new = 1'b1;
         st_next.dac_valid = 1'b1;
      end
      // either edge of the toggle pin, mu-law only
      if ((st_reg.bs_ff[1] != st_reg.bs_last) &&
          st_reg.ctrl[pcm_port_pkg::CTRL_MU_LAW_BIT]) begin
         st_next.dec7 = 1'b1;
         st_next.dec_cnt = st_reg.dec_cnt + 16'h1;
      end
      // write channel: address and data in either order
      if (s_axi_awvalid && !st_reg.aw_done) begin
         st_next.aw_done = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_reg.w_done) begin
         st_next.w_done = 1'b1;
         st_next.w_data = s_axi_wdata;
      end
      if (st_reg.aw_done && st_reg.w_done && !st_reg.bvalid) begin
         st_next.aw_done = 1'b0;
         st_next.w_done = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = pcm_port_pkg::AXI_OKAY;
         case (st_reg.aw_addr)
            pcm_port_pkg::REG_CTRL: st_next.ctrl = st_reg.w_data[1:0];
            pcm_port_pkg::REG_TX_DATA: st_next.tx_word = st_reg.w_data[7:0];
            pcm_port_pkg::REG_STATUS: st_next.rx_new = 1'b0;
            pcm_port_pkg::REG_RX_DATA: st_next.bresp = pcm_port_pkg::AXI_OKAY;
            pcm_port_pkg::REG_DECODE_CNT: begin
               // an edge in the clearing cycle still counts
               st_next.dec_cnt = {15'h0, st_next.dec7};
            end
            default: st_next.bresp = pcm_port_pkg::AXI_SLVERR;
         endcase
         // a word arriving in the clear cycle keeps its flag
         if (st_next.dac_valid) begin
            st_next.rx_new = 1'b1;
         end
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end
      // read: one cycle to answer
      if (s_axi_arvalid && !st_reg.rvalid) begin
         st_next.rvalid = 1'b1;
         st_next.rdata = rd_word;
         st_next.rresp = rd_ok ? pcm_port_pkg::AXI_OKAY :
                                 pcm_port_pkg::AXI_SLVERR;
      end else if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
   end

   // state register, frozen by the clock enable
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         st_reg <= '0;
         st_reg.ctrl <= pcm_port_pkg::CTRL_RESET;
         st_reg.tx_word <= 8'hFF;
         st_reg.tx_hold <= 8'hFF;
         st_reg.bs_ff <= 2'h0;
         st_reg.lb_ff <= 2'h3; // idle pin level: no loopback blip
      end else if (clk_en_i) begin
         st_reg <= st_next;
      end
   end

   // bus handshakes
   assign s_axi_awready = !st_reg.aw_done;
   assign s_axi_wready = !st_reg.w_done;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_arready = !st_reg.rvalid;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;

   // open drain: only a low bit is driven, enable is low while driving
   assign serial_code_output_o = 1'b0;
   // a powered-down section lets go of the shared line
   assign serial_code_output_oe_n_o = tx_line || !tx_active;

   // loopback pin high is normal; register bit can force loopback too
   assign analog_loopback_o = !st_reg.lb_ff[1] ||
      !st_reg.ctrl[pcm_port_pkg::CTRL_LOOPBACK_BIT];
   assign dac_code_o = analog_loopback_o ? 8'hFF : st_reg.rx_word;
   assign dac_valid_o = st_reg.dac_valid;
   assign decode_7bit_o = st_reg.dec7;
   assign tx_powered_o = tx_active;
   assign rx_powered_o = rx_active;
endmodule

/* File: pcm_port_pkg.sv */
// package for the serial pcm codec port: shared constants and carriers
// assumes the core clock at 100 MHz and bit clocks from the highway side
package pcm_port_pkg;
   // word and register layout
   localparam int WORD_BITS = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_TX_DATA = 8'h08;
   localparam logic [7:0] REG_RX_DATA = 8'h0C;
   localparam logic [7:0] REG_DECODE_CNT = 8'h10;
   // control register fields
   localparam int CTRL_LOOPBACK_BIT = 0;
   localparam int CTRL_MU_LAW_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   // status fields
   localparam int STAT_TX_UP_BIT = 0;
   localparam int STAT_RX_UP_BIT = 1;
   localparam int STAT_RX_NEW_BIT = 2;
   localparam int STAT_LOOPBACK_BIT = 3;
   // idle detect: 8 kHz frame is 125 us; allow two frames plus margin
   localparam int CORE_CLK_MHZ = 100;
   localparam int IDLE_TIME_US = 300;
   localparam int IDLE_CYCLES = IDLE_TIME_US * CORE_CLK_MHZ;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   // one section's link pins
   typedef struct packed {
      logic bit_clock;
      logic frame_sync;
      logic data;
   } pcm_pins_t;

   // word handed between domains
   typedef struct packed {
      logic [WORD_BITS-1:0] word;
      logic toggle;
   } pcm_xfer_t;
endpackage

/* File: pcm_activity_detect.sv */
// activity detector: decides whether a frame sync is pulsing or static
// assumes the sync input is already synchronised to core_clk_i
`timescale 1ns/1ps
module pcm_activity_detect #(
   parameter int IDLE_LIMIT = pcm_port_pkg::IDLE_CYCLES
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   // synchronised sync level
   input wire logic sync_level_i,
   // section active
   output logic active_o
);
   typedef struct packed {
      logic last;
      logic active;
      logic [31:0] count;
   } det_state_t;
   det_state_t st_reg;
   det_state_t st_next;

   // any sync edge restarts the static-level timer
   always_comb begin
      st_next = st_reg;
      st_next.last = sync_level_i;
      if (sync_level_i != st_reg.last) begin
         st_next.count = 32'h0;
         st_next.active = 1'b1;
      end else if (st_reg.count >= 32'(IDLE_LIMIT)) begin
         st_next.active = 1'b0;
      end else begin
         st_next.count = st_reg.count + 32'h1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         st_reg <= '0;
      end else if (clk_en_i) begin
         st_reg <= st_next;
      end
   end

   assign active_o = st_reg.active;
endmodule

/* File: pcm_link_section.sv */
// one link section on its own bit clock: shifts a word in or out per frame
// assumes sync and data both sampled on the rising bit clock edge
`timescale 1ns/1ps
module pcm_link_section (
   // link clock and sync
   input wire logic link_clk_i,
   input wire logic frame_sync_i,
   input wire logic serial_in_i,
   // word to send, read only on edges that see the sync
   input wire logic [7:0] tx_word_i,
   // serial out and captured word
   output logic serial_out_o,
   output logic [7:0] rx_word_o,
   output logic rx_toggle_o
);
   typedef struct packed {
      logic [7:0] shift_out;
      logic [7:0] shift_in;
      logic [3:0] bit_cnt;
      logic [7:0] rx_word;
      logic rx_toggle;
      logic out_bit;
   } link_state_t;
   // line starts released so a silent device never holds the shared bus low
   link_state_t st_reg = '{8'hFF, 8'h00, 4'h0, 8'h00, 1'b0, 1'b1};
   link_state_t st_next;

   // sync sampled active starts the word; msb first, one bit per clock
   always_comb begin
      st_next = st_reg;
      if (frame_sync_i) begin
         st_next.out_bit = tx_word_i[7];
         st_next.shift_out = {tx_word_i[6:0], 1'b1};
         st_next.shift_in = {7'h00, serial_in_i};
         st_next.bit_cnt = 4'h1;
      end else if (st_reg.bit_cnt != 4'h0) begin
         st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
         st_next.shift_in = {st_reg.shift_in[6:0], serial_in_i};
         if (st_reg.bit_cnt == 4'h8) begin
            st_next.out_bit = 1'b1; // release line after last bit
            st_next.bit_cnt = 4'h0;
         end else begin
            st_next.out_bit = st_reg.shift_out[7];
            st_next.shift_out = {st_reg.shift_out[6:0], 1'b1};
         end
         if (st_reg.bit_cnt == 4'h7) begin
            st_next.rx_word = {st_reg.shift_in[6:0], serial_in_i};
            st_next.rx_toggle = ~st_reg.rx_toggle;
         end
      end
   end

   // link clock may stop outside frames; no reset in this domain
   always_ff @(posedge link_clk_i) begin
      st_reg <= st_next;
   end

   assign serial_out_o = st_reg.out_bit;
   assign rx_word_o = st_reg.rx_word;
   assign rx_toggle_o = st_reg.rx_toggle;
endmodule

/* File: pcm_port_props.sv */
// checker for the serial pcm port: bus handshakes, pulses, power-down
// assumes only the top module's ports, sampled on the core clock; the two syncs come from the link side
`timescale 1ns/1ps
module pcm_port_props #(
   parameter int IDLE_LIMIT = 200
) (
   // core clock and reset
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // link syncs as seen at the pins
   input wire logic transmit_frame_sync_i,
   input wire logic receive_frame_sync_i,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // outputs under watch
   input wire logic serial_code_output_o,
   input wire logic dac_valid_o,
   input wire logic decode_7bit_o,
   input wire logic tx_powered_o,
   input wire logic rx_powered_o
);
   int t_idle;
   int r_idle;
   logic t_q;
   logic r_q;
   // cycles since each sync last moved; saturates so it never wraps
   always_ff @(posedge core_clk_i) begin
      t_q <= transmit_frame_sync_i;
      r_q <= receive_frame_sync_i;
      if (!reset_n_i || t_q != transmit_frame_sync_i) t_idle <= 0;
      else if (t_idle < IDLE_LIMIT + 16) t_idle <= t_idle + 1;
      if (!reset_n_i || r_q != receive_frame_sync_i) r_idle <= 0;
      else if (r_idle < IDLE_LIMIT + 16) r_idle <= r_idle + 1;
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   // bus answers and holds
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |-> ##[1:2] s_axi_rvalid) else $error("read not answered");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid) else $error("write response dropped");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read moved");
   // pulses and pins
   a_dac_single: assert property (dac_valid_o |=> !dac_valid_o)
      else $error("sample pulse too long");
   a_decode_single: assert property (decode_7bit_o |=> !decode_7bit_o)
      else $error("decode pulse too long");
   a_line_low_only: assert property (serial_code_output_o == 1'h0)
      else $error("serial line driven high");
   a_tx_idle_down: assert property (t_idle == IDLE_LIMIT + 16
      |-> !tx_powered_o) else $error("transmit stays up");
   a_rx_idle_down: assert property (r_idle == IDLE_LIMIT + 16
      |-> !rx_powered_o) else $error("receive stays up");
endmodule
bind pcm_codec_serial_port pcm_port_props #(.IDLE_LIMIT(IDLE_LIMIT)) u_props (.*);

/* File: pcm_highway_model.sv */
// highway partner: bit clocks, frame syncs, receive data, transmit capture
// assumes the codec output shares a pulled-up line; clocks run free
`timescale 1ns/1ps
module pcm_highway_model #(
   parameter int FRAME_BITS = 16
) (
   // frame controls from the bench
   input wire logic tx_run_i,
   input wire logic tx_lvl_i,
   input wire logic rx_run_i,
   input wire logic rx_lvl_i,
   input wire logic [7:0] rx_word_i,
   // codec pins
   input wire logic line_out_i,
   input wire logic line_oe_n_i,
   output logic tx_clk_o,
   output logic tx_sync_o,
   output logic rx_clk_o,
   output logic rx_sync_o,
   output logic rx_data_o,
   // last word seen on the line
   output logic [7:0] tx_word_o,
   output int tx_cnt_o
);
   int t_idx;
   int r_idx;
   int r_nxt;
   int t_pos;
   logic [7:0] sh;
   wire line = line_oe_n_i ? 1'h1 : line_out_i;
   // start-up values
   initial begin
      tx_clk_o = 1'h0;
      rx_clk_o = 1'h0;
      t_idx = 0;
      r_idx = 0;
      t_pos = 8;
      tx_cnt_o = 0;
   end
   // separate clocks, odd phase, so the sections run asynchronously
   always #40 tx_clk_o = ~tx_clk_o;
   initial #23 forever #40 rx_clk_o = ~rx_clk_o;
   // sync and data change mid-cell to meet setup; frame shortened
   always @(negedge tx_clk_o) begin
      t_idx <= (t_idx + 1) % FRAME_BITS;
      tx_sync_o <= tx_run_i ? (t_idx == FRAME_BITS - 1) : tx_lvl_i;
   end
   always @(negedge rx_clk_o) begin
      r_nxt = (r_idx + 1) % FRAME_BITS;
      r_idx <= r_nxt;
      rx_sync_o <= rx_run_i ? (r_nxt == 0) : rx_lvl_i;
      rx_data_o <= (r_nxt < 8) ? rx_word_i[7 - r_nxt] : ~rx_data_o;
   end
   // word starts at the edge that sees sync, read mid-cell msb first
   always @(posedge tx_clk_o) begin
      if (tx_sync_o) t_pos <= 0;
      else if (t_pos < 8) t_pos <= t_pos + 1;
   end
   always @(negedge tx_clk_o) begin
      if (t_pos < 8) begin
         sh = {sh[6:0], line};
         if (t_pos == 7) begin
            tx_word_o <= sh;
            tx_cnt_o <= tx_cnt_o + 1;
         end
      end
   end
endmodule

/* File: tb_pcm_codec_serial_port.sv */
// bench for the serial pcm port: bus, link, control and power scenarios
// assumes the highway model on the link pins and the bound checker
`timescale 1ns/1ps
module tb_pcm_codec_serial_port;
   localparam int IDLE = 200;
   logic core_clk_i = 1'h0, reset_n_i = 1'h0, clk_en_i = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, serial_code_output_o, serial_code_output_oe_n_o;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic transmit_bit_clock_i, transmit_frame_sync_i, receive_bit_clock_i;
   logic receive_frame_sync_i, serial_code_input_i, adc_valid_i = 1'h0;
   logic seven_bit_decode_toggle_i = 1'h0, loopback_select_i = 1'h1;
   logic [7:0] adc_code_i = 8'h00, dac_code_o, rx_word = 8'h00, tx_word;
   logic dac_valid_o, decode_7bit_o, analog_loopback_o;
   logic tx_powered_o, rx_powered_o;
   logic t_run = 1'h1, t_lvl = 1'h0, r_run = 1'h1, r_lvl = 1'h0;
   int n_errors = 0, checked = 0, cycles = 0, n_dec = 0, tx_cnt;
   pcm_codec_serial_port #(.IDLE_LIMIT(IDLE)) u_dut (.*);
   pcm_highway_model #(.FRAME_BITS(16)) u_hw (
      .tx_run_i(t_run), .tx_lvl_i(t_lvl), .rx_run_i(r_run), .rx_lvl_i(r_lvl),
      .rx_word_i(rx_word), .line_out_i(serial_code_output_o),
      .line_oe_n_i(serial_code_output_oe_n_o), .tx_clk_o(transmit_bit_clock_i),
      .tx_sync_o(transmit_frame_sync_i), .rx_clk_o(receive_bit_clock_i),
      .rx_sync_o(receive_frame_sync_i), .rx_data_o(serial_code_input_i),
      .tx_word_o(tx_word), .tx_cnt_o(tx_cnt));
   always #5 core_clk_i = ~core_clk_i;
   // hang ceiling and decode pulse tally
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (decode_7bit_o === 1'h1) n_dec <= n_dec + 1;
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         test_done();
      end
   end
   task automatic test_done();
      if (n_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic clk_n(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   // bus write: both channels offered together, response held for
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'h0;
      w = 1'h0;
      @(posedge core_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!(aw && w)) begin
         @(posedge core_clk_i);
         if (!aw && s_axi_awready === 1'h1) begin
            aw = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (!w && s_axi_wready === 1'h1) begin
            w = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end
      while (s_axi_bvalid !== 1'h1) @(posedge core_clk_i);
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, pcm_port_pkg::AXI_OKAY);
   endtask
   // bus read into rd and rs
   task automatic axi_rd(input logic [7:0] a);
      @(posedge core_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge core_clk_i); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      while (s_axi_rvalid !== 1'h1) @(posedge core_clk_i);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   task automatic wait_dac();
      do @(posedge core_clk_i); while (dac_valid_o !== 1'h1);
   endtask
   // reset values, an unmapped place, both sections up
   task automatic t_bus();
      axi_rd(pcm_port_pkg::REG_CTRL);
      chk(rd, 32'h3);
      axi_rd(8'h14);
      chk(rs, pcm_port_pkg::AXI_SLVERR);
      axi_rd(pcm_port_pkg::REG_STATUS);
      chk(rd[1:0], 2'h3);
   endtask
   // sample handed in; the held copy refreshes after a sync falls,
   // so the third word on is the first one sure to carry it
   task automatic t_tx(input logic [7:0] v);
      int c;
      @(posedge core_clk_i);
      adc_code_i <= v;
      adc_valid_i <= 1'h1;
      @(posedge core_clk_i);
      adc_valid_i <= 1'h0;
      c = tx_cnt;
      while (tx_cnt < c + 3) @(posedge core_clk_i);
      chk(tx_word, v);
   endtask
   // word written over the bus goes out unchanged and reads back
   task automatic t_txreg(input logic [7:0] v);
      int c;
      axi_wr(pcm_port_pkg::REG_TX_DATA, {24'h0, v});
      c = tx_cnt;
      while (tx_cnt < c + 3) @(posedge core_clk_i);
      chk(tx_word, v);
      axi_rd(pcm_port_pkg::REG_TX_DATA);
      chk(rd, {24'h0, v});
   endtask
   // second pulse is clean even if the word changed mid-frame
   task automatic t_rx(input logic [7:0] v);
      @(posedge core_clk_i);
      rx_word <= v;
      wait_dac();
      wait_dac();
      chk(dac_code_o, v);
      axi_rd(pcm_port_pkg::REG_RX_DATA);
      chk(rd[7:0], v);
   endtask
   // one decode per edge of the toggle, rise and fall
   task automatic t_dec();
      int c;
      axi_wr(pcm_port_pkg::REG_DECODE_CNT, 32'h0);
      c = n_dec;
      repeat (2) begin
         seven_bit_decode_toggle_i <= ~seven_bit_decode_toggle_i;
         clk_n(20);
      end
      chk(n_dec - c, 32'h2);
      axi_rd(pcm_port_pkg::REG_DECODE_CNT);
      chk(rd, 32'h2);
      // mu-law off and loopback by register: edge ignored, output forced
      axi_wr(pcm_port_pkg::REG_CTRL, 32'h0);
      seven_bit_decode_toggle_i <= ~seven_bit_decode_toggle_i;
      clk_n(20);
      chk(n_dec - c, 32'h2);
      chk(analog_loopback_o, 1'h1);
      chk(dac_code_o, 8'hFF);
      axi_rd(pcm_port_pkg::REG_STATUS);
      chk(rd[3], 1'h1);
      axi_wr(pcm_port_pkg::REG_CTRL, 32'h3);
   endtask
   // loopback forces the analog side to its zero code
   task automatic t_loop();
      @(posedge core_clk_i);
      loopback_select_i <= 1'h0;
      wait_dac();
      wait_dac();
      chk(analog_loopback_o, 1'h1);
      chk(dac_code_o, 8'hFF);
      loopback_select_i <= 1'h1;
      wait_dac();
      wait_dac();
      chk(analog_loopback_o, 1'h0);
   endtask
   // transmit sync held high, receive held low, then restarted
   task automatic t_pwr();
      int c;
      @(posedge core_clk_i);
      t_run <= 1'h0;
      t_lvl <= 1'h1;
      r_run <= 1'h0;
      clk_n(IDLE + 100);
      chk(tx_powered_o, 1'h0);
      chk(rx_powered_o, 1'h0);
      axi_rd(pcm_port_pkg::REG_STATUS);
      chk(rd[1:0], 2'h0);
      chk(serial_code_output_oe_n_o, 1'h1);
      t_run <= 1'h1;
      r_run <= 1'h1;
      while (!(tx_powered_o === 1'h1 && rx_powered_o === 1'h1)) clk_n(1);
      // first word after wake-up may be cut; the next must be whole
      c = tx_cnt;
      while (tx_cnt < c + 2) clk_n(1);
      chk(tx_word, 8'h5C);
   endtask
   // main sequence
   initial begin
      clk_n(8);
      reset_n_i <= 1'h1;
      while (tx_cnt < 2 || rx_powered_o !== 1'h1) clk_n(1);
      t_bus();
      t_tx(8'hC1);
      t_tx(8'h3A);
      t_txreg(8'h5C);
      t_rx(8'h96);
      t_rx(8'h6B);
      t_dec();
      t_loop();
      t_pwr();
      test_done();
   end
endmodule
